// ---- pkg/uri_defs.svh ----
// Offsets, field positions, reset values and counts of the serial block.
// Assumes an 8-bit I/O bus with a three-bit register index.
`ifndef URI_DEFS_SVH
`define URI_DEFS_SVH

`define URI_ADDR_DATA 3'h0
`define URI_ADDR_STATUS 3'h1
`define URI_ADDR_CONTROL 3'h2
`define URI_ADDR_BAUD_LOW 3'h3
`define URI_ADDR_SHARED 3'h4

`define URI_BIT_RX_DONE 7
`define URI_BIT_TX_DONE 6
`define URI_BIT_TX_EMPTY 5
`define URI_BIT_FRAME_ERR 4
`define URI_BIT_OVERRUN 3
`define URI_BIT_PARITY_ERR 2
`define URI_BIT_DOUBLE 1
`define URI_BIT_MULTIPROC 0

`define URI_BIT_RX_IE 7
`define URI_BIT_TX_IE 6
`define URI_BIT_EMPTY_IE 5
`define URI_BIT_RX_EN 4
`define URI_BIT_TX_EN 3
`define URI_BIT_SIZE_TOP 2
`define URI_BIT_RX_NINTH 1
`define URI_BIT_TX_NINTH 0

`define URI_BIT_SEL 7
`define URI_BIT_SYNC 6
`define URI_BIT_PAR_EN 5
`define URI_BIT_PAR_ODD 4
`define URI_BIT_STOP2 3
`define URI_BIT_SIZE_HI 2
`define URI_BIT_SIZE_LO 1

`define URI_RST_STATUS 8'h20
`define URI_RST_CONTROL 8'h00
`define URI_RST_FRAME 7'h06
`define URI_RST_DIV_HI 4'h0
`define URI_RST_DIV_LO 8'h00

`define URI_OVS_NORMAL 5'd16
`define URI_OVS_DOUBLE 5'd8
`define URI_FIFO_DEPTH 2

`endif

// ---- pkg/uri_pkg.sv ----
// Types shared by the serial block.
// Assumes uri_defs.svh is compiled with it.
package uri_pkg;

  typedef struct packed {
    logic ninth;
    logic frame_err;
    logic parity_err;
    logic [7:0] data;
  } uri_rx_entry_s;

  typedef enum logic [1:0] {
    URI_TX_IDLE = 2'b01,
    URI_TX_SEND = 2'b10
  } uri_tx_state_e;

  typedef enum logic [2:0] {
    URI_RX_IDLE = 3'b001,
    URI_RX_START = 3'b010,
    URI_RX_BITS = 3'b100
  } uri_rx_state_e;

endpackage

// ---- core/uri_baud_gen.sv ----
// Oversample tick generator: one tick every divisor+1 clocks.
// Assumes the divisor is stable except when reload is pulsed.
`timescale 1ns/1ns
module uri_baud_gen #(
  parameter int DIV_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic reload,
  output logic tick
);
  logic [DIV_W-1:0] count;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      tick <= 1'b0;
    end else if (reload) begin
      // Restart at once; this edge reloads the divisor held before the write
      count <= divisor;
      tick <= 1'b0;
    end else if (count == '0) begin
      count <= divisor;
      tick <= 1'b1;
    end else begin
      count <= count - 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// ---- core/uri_top.sv ----
// Serial transceiver with its register file on an 8-bit I/O port.
// Assumes a CPU bus with one-cycle read and write strobes on clk.
`timescale 1ns/1ns
`include "uri_defs.svh"
module uri_top
  import uri_pkg::*;
#(
  parameter int DIV_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic global_irq_en,
  input wire logic tx_done_ack,
  input wire logic rxd,
  output logic txd,
  output logic txd_drive_n,
  output logic rxd_owned,
  output logic irq_rx_done,
  output logic irq_tx_done,
  output logic irq_tx_empty
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] control_b;
  logic [6:0] frame_fmt;
  logic [3:0] div_high;
  logic [7:0] div_low;
  logic double_speed_bit;
  logic multiproc_filter_bit;
  logic tx_complete_flag;
  logic overrun_flag;
  logic prev_shared_rd;
  logic tick;
  localparam logic [7:0] RST_STATUS = `URI_RST_STATUS;

  wire wr_data = io_wr && (io_addr == `URI_ADDR_DATA);
  wire wr_status = io_wr && (io_addr == `URI_ADDR_STATUS);
  wire wr_control = io_wr && (io_addr == `URI_ADDR_CONTROL);
  wire wr_baud_low = io_wr && (io_addr == `URI_ADDR_BAUD_LOW);
  wire wr_shared = io_wr && (io_addr == `URI_ADDR_SHARED);
  wire rd_data = io_rd && (io_addr == `URI_ADDR_DATA);
  wire rd_shared = io_rd && (io_addr == `URI_ADDR_SHARED);

  wire receiver_enable = control_b[`URI_BIT_RX_EN];
  wire transmitter_enable = control_b[`URI_BIT_TX_EN];
  wire sync_mode = frame_fmt[`URI_BIT_SYNC];
  wire parity_enable_bit = frame_fmt[`URI_BIT_PAR_EN];
  wire parity_odd = frame_fmt[`URI_BIT_PAR_ODD];
  wire two_stop = frame_fmt[`URI_BIT_STOP2];
  wire [2:0] size_code = {control_b[`URI_BIT_SIZE_TOP],
                          frame_fmt[`URI_BIT_SIZE_HI],
                          frame_fmt[`URI_BIT_SIZE_LO]};

  // Reserved size codes fall back to eight bits
  wire [3:0] nbits = (size_code == 3'h7) ? 4'h9 :
                     (size_code[2]) ? 4'h8 : (4'h5 + {2'h0, size_code[1:0]});
  wire [4:0] ovs = (double_speed_bit && !sync_mode) ?
                   `URI_OVS_DOUBLE : `URI_OVS_NORMAL;
  wire [4:0] ovs_last = ovs - 5'd1;
  wire [4:0] ovs_half = (ovs >> 1) - 5'd1;

  logic [8:0] char_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_mask
      assign char_mask[gi] = (4'(gi) < nbits);
    end
  endgenerate

  uri_baud_gen #(
    .DIV_W(DIV_W)
  ) u_baud (
    .clk(clk),
    .rst(rst),
    .divisor({div_high, div_low}),
    .reload(wr_baud_low),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path
  uri_tx_state_e tx_state;
  logic tx_full;
  logic [8:0] tx_buffer;
  logic [12:0] tx_shift;
  logic [3:0] tx_bits_left;
  logic [4:0] tx_tick_cnt;
  logic [12:0] tx_frame;

  wire tx_owned = !txd_drive_n;
  wire tx_accept = wr_data && !tx_full;
  wire tx_load = (tx_state == URI_TX_IDLE) && tx_full && tx_owned;
  wire tx_bit_end = (tx_state == URI_TX_SEND) && tick &&
                    (tx_tick_cnt == ovs_last);
  wire tx_frame_end = tx_bit_end && (tx_bits_left == 4'h1);
  wire [8:0] tx_masked = tx_buffer & char_mask;
  wire tx_parity = (^tx_masked) ^ parity_odd;
  wire [3:0] tx_len = 4'h2 + nbits + {3'h0, parity_enable_bit} +
                      {3'h0, two_stop};

  always_comb begin
    tx_frame = 13'h1fff;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nbits) begin
        tx_frame[i+1] = tx_masked[i];
      end
    end
    if (parity_enable_bit) begin
      tx_frame[nbits+4'h1] = tx_parity;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_full <= 1'b0;
      tx_buffer <= 9'h000;
    end else if (tx_accept) begin
      tx_full <= 1'b1;
      tx_buffer <= {control_b[`URI_BIT_TX_NINTH], io_wdata};
    end else if (tx_load) begin
      tx_full <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state <= URI_TX_IDLE;
      tx_shift <= 13'h1fff;
      tx_bits_left <= 4'h0;
      tx_tick_cnt <= 5'd0;
    end else if (tx_load) begin
      tx_state <= URI_TX_SEND;
      tx_shift <= tx_frame;
      tx_bits_left <= tx_len;
      tx_tick_cnt <= 5'd0;
    end else if (tx_frame_end) begin
      tx_state <= URI_TX_IDLE;
      tx_shift <= 13'h1fff;
    end else if (tx_bit_end) begin
      tx_shift <= {1'b1, tx_shift[12:1]};
      tx_bits_left <= tx_bits_left - 4'h1;
      tx_tick_cnt <= 5'd0;
    end else if ((tx_state == URI_TX_SEND) && tick) begin
      tx_tick_cnt <= tx_tick_cnt + 5'd1;
    end
  end

  // Pin stays driven while anything remains to be sent
  wire tx_drained = (tx_state == URI_TX_IDLE) && !tx_full;
  wire next_tx_owned = transmitter_enable || (tx_owned && !tx_drained);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txd_drive_n <= 1'b1;
      txd <= 1'b1;
    end else begin
      txd_drive_n <= !next_tx_owned;
      txd <= (tx_state == URI_TX_SEND) ? tx_shift[0] : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path
  uri_rx_state_e rx_state;
  logic rxd_meta;
  logic rxd_sync;
  logic [10:0] rx_shift;
  logic [3:0] rx_idx;
  logic [4:0] rx_tick_cnt;
  logic rx_done;
  uri_rx_entry_s rx_mem [`URI_FIFO_DEPTH];
  uri_rx_entry_s rx_hold;
  logic rx_hold_valid;
  logic rx_rd_ptr;
  logic [1:0] rx_count;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
    end
  end

  wire [3:0] rx_total = nbits + {3'h0, parity_enable_bit} + 4'h1;
  wire rx_start_seen = (rx_state == URI_RX_IDLE) && !rxd_sync;
  wire rx_sample_start = (rx_state == URI_RX_START) && tick &&
                         (rx_tick_cnt == ovs_half);
  wire rx_sample_bit = (rx_state == URI_RX_BITS) && tick &&
                       (rx_tick_cnt == ovs_last);
  wire rx_last_bit = rx_sample_bit && (rx_idx == rx_total - 4'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state <= URI_RX_IDLE;
      rx_shift <= 11'h000;
      rx_idx <= 4'h0;
      rx_tick_cnt <= 5'd0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= rx_last_bit && receiver_enable;
      case (rx_state)
        URI_RX_IDLE: begin
          rx_tick_cnt <= 5'd0;
          rx_idx <= 4'h0;
          if (receiver_enable && rx_start_seen) begin
            rx_state <= URI_RX_START;
          end
        end
        URI_RX_START: begin
          if (!receiver_enable) begin
            rx_state <= URI_RX_IDLE;
          end else if (rx_sample_start) begin
            // Glitch rejection: start bit must still be low mid-bit
            rx_state <= rxd_sync ? URI_RX_IDLE : URI_RX_BITS;
            rx_tick_cnt <= 5'd0;
          end else if (tick) begin
            rx_tick_cnt <= rx_tick_cnt + 5'd1;
          end
        end
        URI_RX_BITS: begin
          if (!receiver_enable || rx_last_bit) begin
            rx_state <= URI_RX_IDLE;
          end
          if (rx_sample_bit) begin
            rx_shift[rx_idx] <= rxd_sync;
            rx_idx <= rx_idx + 4'h1;
            rx_tick_cnt <= 5'd0;
          end else if (tick) begin
            rx_tick_cnt <= rx_tick_cnt + 5'd1;
          end
        end
        default: begin
          rx_state <= URI_RX_IDLE;
        end
      endcase
    end
  end

  // Decode the finished frame one cycle after its last sample
  wire [8:0] rx_data9 = rx_shift[8:0] & char_mask;
  wire rx_stop_bit = rx_shift[nbits + {3'h0, parity_enable_bit}];
  wire rx_par_bad = parity_enable_bit &&
                    ((^rx_data9) ^ parity_odd ^ rx_shift[nbits]);
  wire rx_type_bit = (nbits == 4'h9) ? rx_data9[8] : rx_stop_bit;
  wire rx_drop = multiproc_filter_bit && !rx_type_bit;
  wire rx_new = rx_done && !rx_drop;
  uri_rx_entry_s rx_word;
  assign rx_word = '{ninth: rx_data9[8], frame_err: !rx_stop_bit,
                     parity_err: rx_par_bad, data: rx_data9[7:0]};

  wire rx_pop = rd_data && (rx_count != 2'd0);
  wire [1:0] rx_after_pop = rx_count - {1'b0, rx_pop};
  wire rx_space = (rx_after_pop != 2'd2);
  wire rx_push_hold = rx_hold_valid && rx_space;
  wire rx_push_new = rx_new && rx_space && !rx_hold_valid;
  wire rx_push = rx_push_hold || rx_push_new;
  wire rx_to_hold = rx_new && (rx_push_hold || !rx_space) &&
                    !(rx_hold_valid && !rx_space);
  wire rx_next_ptr = rx_rd_ptr ^ rx_pop;
  wire rx_wr_idx = rx_next_ptr ^ rx_after_pop[0];
  wire rx_overrun_evt = rx_start_seen && receiver_enable &&
                        (rx_count == 2'd2) && rx_hold_valid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_rd_ptr <= 1'b0;
      rx_count <= 2'd0;
      rx_hold_valid <= 1'b0;
      rx_hold <= '0;
      rx_mem[0] <= '0;
      rx_mem[1] <= '0;
    end else if (!receiver_enable) begin
      rx_count <= 2'd0;
      rx_hold_valid <= 1'b0;
    end else begin
      rx_rd_ptr <= rx_next_ptr;
      rx_count <= rx_after_pop + {1'b0, rx_push};
      if (rx_push) begin
        rx_mem[rx_wr_idx] <= rx_push_hold ? rx_hold : rx_word;
      end
      if (rx_to_hold) begin
        rx_hold <= rx_word;
      end
      rx_hold_valid <= rx_to_hold || (rx_hold_valid && !rx_space);
    end
  end

  uri_rx_entry_s rx_head;
  assign rx_head = rx_mem[rx_rd_ptr];
  wire rx_complete_flag = (rx_count != 2'd0);
  wire head_frame_err = rx_complete_flag && rx_head.frame_err;
  wire head_parity_err = rx_complete_flag && rx_head.parity_err;

  ////////////////////////////////////////////////////////////////////////////
  // Control and status registers
  wire tx_done_set = tx_frame_end && !tx_full;
  wire tx_done_clr = tx_done_ack ||
                     (wr_status && io_wdata[`URI_BIT_TX_DONE]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_b <= `URI_RST_CONTROL;
      frame_fmt <= `URI_RST_FRAME;
      div_high <= `URI_RST_DIV_HI;
      div_low <= `URI_RST_DIV_LO;
      double_speed_bit <= RST_STATUS[`URI_BIT_DOUBLE];
      multiproc_filter_bit <= RST_STATUS[`URI_BIT_MULTIPROC];
      tx_complete_flag <= RST_STATUS[`URI_BIT_TX_DONE];
      overrun_flag <= RST_STATUS[`URI_BIT_OVERRUN];
      prev_shared_rd <= 1'b0;
    end else begin
      prev_shared_rd <= rd_shared;
      tx_complete_flag <= tx_done_set || (tx_complete_flag && !tx_done_clr);
      if (!receiver_enable) begin
        overrun_flag <= 1'b0;
      end else begin
        overrun_flag <= rx_overrun_evt || (overrun_flag && !rx_pop);
      end
      if (wr_status) begin
        double_speed_bit <= io_wdata[`URI_BIT_DOUBLE];
        multiproc_filter_bit <= io_wdata[`URI_BIT_MULTIPROC];
      end
      if (wr_control) begin
        control_b <= io_wdata;
      end
      if (wr_baud_low) begin
        div_low <= io_wdata;
      end
      if (wr_shared && io_wdata[`URI_BIT_SEL]) begin
        frame_fmt <= io_wdata[6:0];
      end else if (wr_shared) begin
        div_high <= io_wdata[3:0];
      end
    end
  end

  wire [7:0] status_a = {rx_complete_flag, tx_complete_flag, !tx_full,
                         head_frame_err, overrun_flag, head_parity_err,
                         double_speed_bit, multiproc_filter_bit};
  // Receive ninth bit is live from the FIFO head, never stored
  wire [7:0] control_rd = {control_b[7:2], rx_head.ninth & rx_complete_flag,
                           control_b[`URI_BIT_TX_NINTH]};
  wire [7:0] shared_rd = prev_shared_rd ? {1'b1, frame_fmt} :
                         {4'h0, div_high};
  wire [7:0] next_rdata =
    (io_addr == `URI_ADDR_DATA) ? (rx_complete_flag ? rx_head.data : 8'h00) :
    (io_addr == `URI_ADDR_STATUS) ? status_a :
    (io_addr == `URI_ADDR_CONTROL) ? control_rd :
    (io_addr == `URI_ADDR_BAUD_LOW) ? div_low :
    (io_addr == `URI_ADDR_SHARED) ? shared_rd : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rdata <= 8'h00;
      rxd_owned <= 1'b0;
      irq_rx_done <= 1'b0;
      irq_tx_done <= 1'b0;
      irq_tx_empty <= 1'b0;
    end else begin
      if (io_rd) begin
        io_rdata <= next_rdata;
      end
      rxd_owned <= receiver_enable;
      irq_rx_done <= control_b[`URI_BIT_RX_IE] && global_irq_en &&
                     rx_complete_flag;
      irq_tx_done <= control_b[`URI_BIT_TX_IE] && global_irq_en &&
                     tx_complete_flag;
      irq_tx_empty <= control_b[`URI_BIT_EMPTY_IE] && global_irq_en &&
                      !tx_full;
    end
  end

endmodule

// ---- tb/uri_top_sva.sv ----
// Checker for the register port and serial pins of uri_top.
// Assumes it is bound to uri_top and sees only its ports.
`timescale 1ns/1ns
module uri_top_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic global_irq_en,
  input wire logic txd,
  input wire logic txd_drive_n,
  input wire logic rxd_owned,
  input wire logic irq_rx_done,
  input wire logic irq_tx_done,
  input wire logic irq_tx_empty
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic prev_sh;
  logic [3:0] div_hi;
  logic [6:0] frame;
  wire sh_rd = io_rd && io_addr == 3'h4;
  wire sh_wr = io_wr && io_addr == 3'h4;
  ////////////////////////////////////////////////////////////////////////
  // Shadow of the shared location, fed from bus writes only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_sh <= 1'b0;
      div_hi <= 4'h0;
      frame <= 7'h06;
    end else begin
      prev_sh <= sh_rd;
      if (sh_wr && !io_wdata[7]) div_hi <= io_wdata[3:0];
      if (sh_wr && io_wdata[7]) frame <= io_wdata[6:0];
    end
  end
  property p_div_read;
    sh_rd && !prev_sh |=> io_rdata == {4'h0, div_hi};
  endproperty
  a_div_read: assert property (p_div_read)
    else $error("lone shared read wrong");
  property p_frame_read;
    sh_rd && prev_sh |=> io_rdata == {1'b1, frame};
  endproperty
  a_frame_read: assert property (p_frame_read)
    else $error("second shared read wrong");
  property p_unmapped;
    io_rd && io_addr > 3'h4 |=> io_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_rdata_hold;
    !io_rd |=> $stable(io_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without read");
  property p_irq_gate;
    irq_rx_done || irq_tx_done || irq_tx_empty |-> $past(global_irq_en);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("request with global flag off");
  property p_rx_own;
    io_wr && io_addr == 3'h2 |-> ##2 rxd_owned == $past(io_wdata[4], 2);
  endproperty
  a_rx_own: assert property (p_rx_own)
    else $error("input pin ownership wrong");
  property p_pin_idle;
    txd_drive_n |-> txd;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("released pin not idle");
  property p_start_own;
    $fell(txd) |-> !txd_drive_n;
  endproperty
  a_start_own: assert property (p_start_own)
    else $error("start bit on unowned pin");
  c_frame_read: cover property (sh_rd && prev_sh);
  c_start: cover property ($fell(txd));
  c_irq: cover property (irq_tx_empty);
endmodule
bind uri_top uri_top_sva i_uri_top_sva (
  .clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
  .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .global_irq_en(global_irq_en), .txd(txd), .txd_drive_n(txd_drive_n),
  .rxd_owned(rxd_owned), .irq_rx_done(irq_rx_done),
  .irq_tx_done(irq_tx_done), .irq_tx_empty(irq_tx_empty)
);

// ---- tb/uri_partner.sv ----
// Remote transceiver on the serial pins.
// Assumes divisor 0: bit_clks clocks per bit, 16 or 8 at double speed.
`timescale 1ns/1ns
module uri_partner (
  input wire logic clk,
  input wire logic txd,
  input wire logic txd_drive_n,
  output logic rxd
);
  int bit_clks = 16;
  // Released output pin floats to its pull-up level
  wire line = txd_drive_n ? 1'b1 : txd;
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] d, input int n, input logic stop);
    @(posedge clk);
    #2 rxd = 1'b0;
    repeat (bit_clks) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      #2 rxd = d[i];
      repeat (bit_clks) @(posedge clk);
    end
    #2 rxd = stop;
    repeat (bit_clks) @(posedge clk);
    #2 rxd = 1'b1;
    repeat (bit_clks) @(posedge clk);
  endtask
  // Returns got=1 only for a frame whose stop bit was high
  task automatic catch(output logic [7:0] d, output logic got);
    int w;
    d = 8'h00;
    got = 1'b0;
    for (w = 0; w < 600 && line; w++) @(posedge clk);
    if (!line) begin
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_clks) @(posedge clk);
        d[i] = line;
      end
      repeat (bit_clks) @(posedge clk);
      got = line;
    end
  endtask
endmodule

// ---- tb/uri_top_tb.sv ----
// Self-checking bench for uri_top with a remote transceiver model.
// Assumes divisor 0 stays set, so 16 (or 8 doubled) clocks per bit.
`timescale 1ns/1ns
module uri_top_tb;
  logic clk, rst, io_wr, io_rd, global_irq_en, tx_done_ack;
  logic [2:0] io_addr;
  logic [7:0] io_wdata, io_rdata, v;
  logic txd, txd_drive_n, rxd, rxd_owned, irq_rx_done, irq_tx_done;
  logic irq_tx_empty;
  int fail_count, checks, cycles;
  uri_top i_uri_top (.clk(clk), .rst(rst), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .global_irq_en(global_irq_en), .tx_done_ack(tx_done_ack), .rxd(rxd),
    .txd(txd), .txd_drive_n(txd_drive_n), .rxd_owned(rxd_owned),
    .irq_rx_done(irq_rx_done), .irq_tx_done(irq_tx_done),
    .irq_tx_empty(irq_tx_empty));
  uri_partner i_uri_partner (.clk(clk), .txd(txd),
    .txd_drive_n(txd_drive_n), .rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Twelve frames plus waits fit well inside this ceiling
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #2 io_wr = 1'b0;
  endtask
  // n back-to-back reads; q is the answer to the last one
  task automatic rd(input logic [2:0] a, input int n, output logic [7:0] q);
    @(posedge clk);
    #2 io_addr = a;
    io_rd = 1'b1;
    repeat (n) @(posedge clk);
    #2 io_rd = 1'b0;
    q = io_rdata;
  endtask
  task automatic t_reset();
    rd(3'h1, 1, v);
    chk(v, 8'h20);
    rd(3'h2, 1, v);
    chk(v, 8'h00);
    rd(3'h4, 1, v);
    chk(v, 8'h00);
    rd(3'h4, 2, v);
    chk(v, 8'h86);
    rd(3'h5, 1, v);
    chk(v, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_shared();
    wr(3'h4, 8'h05);
    rd(3'h4, 1, v);
    chk(v, 8'h05);
    wr(3'h4, 8'h87);
    rd(3'h4, 3, v);
    chk(v, 8'h87);
    wr(3'h4, 8'h00);
    wr(3'h4, 8'h86);
    // Low byte write restarts the prescaler at the restored divisor
    wr(3'h3, 8'h00);
    $display("test shared done");
  endtask
  task automatic t_tx();
    logic [7:0] a, b;
    logic ga, gb;
    wr(3'h2, 8'h08);
    fork
      begin
        i_uri_partner.catch(a, ga);
        i_uri_partner.catch(b, gb);
      end
      begin
        wr(3'h0, 8'ha5);
        repeat (4) @(posedge clk);
        wr(3'h0, 8'h5a);
        wr(3'h0, 8'hff);
        rd(3'h1, 1, v);
        chk(v, 8'h00);
        wr(3'h2, 8'h00);
      end
    join
    chk(a, 8'ha5);
    chk(b, 8'h5a);
    chk({6'h0, ga, gb}, 8'h03);
    i_uri_partner.catch(a, ga);
    chk({7'h0, ga}, 8'h00);
    chk({7'h0, txd_drive_n}, 8'h01);
    rd(3'h1, 1, v);
    chk(v, 8'h60);
    tx_done_ack = 1'b1;
    @(posedge clk);
    #2 tx_done_ack = 1'b0;
    rd(3'h1, 1, v);
    chk(v, 8'h20);
    $display("test tx done");
  endtask
  task automatic t_rx();
    wr(3'h2, 8'h10);
    i_uri_partner.send(8'h3c, 8, 1'b1);
    i_uri_partner.send(8'hc3, 8, 1'b0);
    rd(3'h1, 1, v);
    chk(v, 8'ha0);
    rd(3'h0, 1, v);
    chk(v, 8'h3c);
    rd(3'h1, 1, v);
    chk(v, 8'hb0);
    rd(3'h0, 1, v);
    chk(v, 8'hc3);
    rd(3'h1, 1, v);
    chk(v, 8'h20);
    wr(3'h4, 8'h80);
    i_uri_partner.send(8'hff, 5, 1'b1);
    rd(3'h0, 1, v);
    chk(v, 8'h1f);
    wr(3'h4, 8'h86);
    wr(3'h1, 8'h01);
    i_uri_partner.send(8'h55, 8, 1'b0);
    i_uri_partner.send(8'h66, 8, 1'b1);
    rd(3'h0, 1, v);
    chk(v, 8'h66);
    wr(3'h1, 8'h00);
    $display("test rx done");
  endtask
  task automatic t_overrun();
    i_uri_partner.send(8'h11, 8, 1'b1);
    i_uri_partner.send(8'h22, 8, 1'b1);
    i_uri_partner.send(8'h33, 8, 1'b1);
    i_uri_partner.send(8'h44, 8, 1'b1);
    rd(3'h1, 1, v);
    chk(v, 8'ha8);
    rd(3'h0, 1, v);
    chk(v, 8'h11);
    wr(3'h2, 8'h00);
    rd(3'h1, 1, v);
    chk(v, 8'h20);
    chk({7'h0, rxd_owned}, 8'h00);
    $display("test overrun done");
  endtask
  task automatic t_dbl();
    logic [7:0] a;
    logic ga;
    wr(3'h1, 8'h02);
    i_uri_partner.bit_clks = 8;
    wr(3'h2, 8'h08);
    fork
      i_uri_partner.catch(a, ga);
      wr(3'h0, 8'h96);
    join
    wr(3'h2, 8'h00);
    repeat (8) @(posedge clk);
    chk(a, 8'h96);
    chk({7'h0, ga}, 8'h01);
    rd(3'h1, 1, v);
    chk(v, 8'h62);
    i_uri_partner.bit_clks = 16;
    $display("test double speed done");
  endtask
  task automatic t_irq();
    wr(3'h2, 8'he0);
    repeat (3) @(posedge clk);
    #2 chk({6'h0, irq_tx_done, irq_tx_empty}, 8'h00);
    global_irq_en = 1'b1;
    repeat (2) @(posedge clk);
    #2 chk({5'h0, irq_tx_done, irq_tx_empty, irq_rx_done}, 8'h06);
    wr(3'h1, 8'h40);
    repeat (2) @(posedge clk);
    #2 chk({7'h0, irq_tx_done}, 8'h00);
    wr(3'h2, 8'h00);
    repeat (2) @(posedge clk);
    #2 chk({7'h0, irq_tx_empty}, 8'h00);
    $display("test irq done");
  endtask
  initial begin
    rst = 1'b1;
    io_addr = 3'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    global_irq_en = 1'b0;
    tx_done_ack = 1'b0;
    repeat (12) @(posedge clk);
    #2 rst = 1'b0;
    t_reset();
    t_shared();
    t_tx();
    t_rx();
    t_overrun();
    t_dbl();
    t_irq();
    print_verdict();
  end
endmodule
